// File: src/serial_command_rx_polling.sv
// Notes on behaviour
// - register write takes one or more bytes to successive register addresses
// - during register writes the command and each data byte before the last echo on data out
// - power-off acts only with analog supply off, wake low, all keys high
// - interrupt clear command drives the interrupt request output low
// - top three bits give the command type, lower five the register address
// - lower five bits are ignored for non-register commands
// - 000 buf read, 001 buf write, 010 reg read, 011 reg write, 100 off, 101 irq
// - data moves bit by bit on the host serial clock over four lines
// - no transfers accepted or returned while reset output is asserted
// - chip select low, transparent off: data out floats
// - chip select low, transparent on: demodulated data drives data out
// - mode bits 1,0 select polling, 1,1 select continuous receive
// - polling repeats sleep, start-up, edge check; back to sleep on failure
// - start-up enables PLL first, signal processing only after lock
// - in polling mode only a valid signal keeps the receiver active and delivering data
// - continuous mode keeps the receiver on with no sleep phases
// - sleep lasts sleep field times 1024 base ticks times extension factor
// - extension bit clear gives factor one, set gives factor eight
// - receiver-active output shows the receive operation condition
// - bytes move msb first; port held in reset while chip select is low
// - while the command shifts in, the buffer byte count shifts out
// - pending interrupt clears by status read or interrupt clear command; here only the clear command clears it
module serial_command_rx_polling
  import serial_cmd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        serial_clk,
  input  wire logic        chip_select,
  input  wire logic        serial_data_in_line,
  output logic             serial_data_out_line,
  output logic             serial_data_out_oe,
  input  wire logic        reset_out_n,
  input  wire logic        transparent_mode,
  input  wire logic        analog_supply_enable,
  input  wire logic        wake_input,
  input  wire logic [3:0]  key_input,
  input  wire logic        base_digital_tick,
  input  wire logic [4:0]  sleep_field,
  input  wire logic        sleep_extension_bit,
  input  wire logic [7:0]  buffer_byte_count,
  input  wire logic [7:0]  read_data,
  input  wire logic        demod_data,
  input  wire logic        pll_locked,
  input  wire logic        check_valid,
  input  wire logic        check_failed,
  input  wire logic        irq_event,
  output logic             irq_request,
  output logic             off_mode_request,
  output logic             reg_write_strobe,
  output logic [4:0]       reg_write_addr,
  output logic [7:0]       reg_write_data,
  output logic             op_mode_low_bit,
  output logic             op_mode_high_bit,
  output logic             pll_enable,
  output logic             sig_proc_enable,
  output logic             check_enable,
  output logic             rx_deliver,
  output logic             receiver_active
);
  function automatic logic [2:0] cmd_type(input logic [7:0] b);
    cmd_type = b[CMD_TYPE_MSB:CMD_TYPE_LSB];
  endfunction

  // ---------------- link side, serial_clk domain ----------------
  // port logic is in reset whenever chip select is low, or device reset is out
  logic        port_rst;
  assign port_rst = ~chip_select | ~reset_out_n;

  link_state_t lstate_q;
  link_state_t lstate_d;
  logic [2:0]  bitcnt_q;
  logic [2:0]  bitcnt_d;
  logic [7:0]  shin_q;
  logic [7:0]  shin_d;
  logic [2:0]  ctype_q;
  logic [2:0]  ctype_d;
  logic [4:0]  addr_q;
  logic [4:0]  addr_d;
  logic [7:0]  wdata_q;
  logic [7:0]  wdata_d;
  logic        wr_tog_q;
  logic        wr_tog_d;
  logic        off_tog_q;
  logic        off_tog_d;
  logic        clr_tog_q;
  logic        clr_tog_d;
  logic [7:0]  next_in;
  logic        byte_end;

  always_comb begin
    next_in  = {shin_q[6:0], serial_data_in_line};
    byte_end = (bitcnt_q == 3'h7);
    lstate_d = lstate_q;
    bitcnt_d = bitcnt_q + 3'h1;
    shin_d   = next_in;
    ctype_d  = ctype_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    wr_tog_d = wr_tog_q;
    off_tog_d = off_tog_q;
    clr_tog_d = clr_tog_q;
    if (byte_end) begin
      case (lstate_q)
        LINK_CMD: begin
          ctype_d = cmd_type(next_in);
          addr_d  = next_in[CMD_ADDR_MSB:CMD_ADDR_LSB];
          case (cmd_type(next_in))
            CMD_REG_WRITE, CMD_REG_READ, CMD_BUF_READ, CMD_BUF_WRITE: lstate_d = LINK_DATA;
            CMD_POWER_OFF: begin
              off_tog_d = ~off_tog_q;
              lstate_d  = LINK_DONE;
            end
            CMD_IRQ_CLEAR: begin
              clr_tog_d = ~clr_tog_q;
              lstate_d  = LINK_DONE;
            end
            default: lstate_d = LINK_IGNORE;
          endcase
        end
        LINK_DATA: begin
          if (ctype_q == CMD_REG_WRITE) begin
            wdata_d  = next_in;
            wr_tog_d = ~wr_tog_q;
          end
        end
        default: lstate_d = lstate_q;
      endcase
    end
  end

  always_ff @(posedge serial_clk or posedge port_rst) begin
    if (port_rst) begin
      lstate_q  <= LINK_CMD;
      bitcnt_q  <= 3'h0;
      shin_q    <= 8'h00;
      ctype_q   <= CMD_BUF_READ;
      addr_q    <= 5'h00;
      wdata_q   <= 8'h00;
    end else begin
      lstate_q  <= lstate_d;
      bitcnt_q  <= bitcnt_d;
      shin_q    <= shin_d;
      ctype_q   <= ctype_d;
      addr_q    <= addr_d;
      wdata_q   <= wdata_d;
    end
  end

  // toggles survive chip select release so no event is lost across frames;
  // sys_rst clears both ends of each crossing together, so no false pulse
  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_tog_q  <= 1'b0;
      off_tog_q <= 1'b0;
      clr_tog_q <= 1'b0;
    end else if (!port_rst) begin
      wr_tog_q  <= wr_tog_d;
      off_tog_q <= off_tog_d;
      clr_tog_q <= clr_tog_d;
    end
  end

  // write address counter: advances after each data byte for burst writes
  logic [4:0] waddr_q;
  logic [4:0] waddr_d;
  always_comb begin
    waddr_d = waddr_q;
    if (byte_end && lstate_q == LINK_CMD) begin
      waddr_d = next_in[CMD_ADDR_MSB:CMD_ADDR_LSB];
    end else if (byte_end && lstate_q == LINK_DATA) begin
      waddr_d = waddr_q + 5'h01;
    end
  end
  logic [4:0] wr_addr_hold_q;
  always_ff @(posedge serial_clk or posedge port_rst) begin
    if (port_rst) begin
      waddr_q <= 5'h00;
    end else begin
      waddr_q <= waddr_d;
    end
  end
  always_ff @(posedge serial_clk) begin
    if (byte_end && lstate_q == LINK_DATA && ctype_q == CMD_REG_WRITE && !port_rst) begin
      wr_addr_hold_q <= waddr_q;
    end
  end

  // output shifter, updated on falling edge
  logic [7:0] shout_q;
  logic [7:0] shout_d;
  logic       first_q;
  always_comb begin
    shout_d = {shout_q[6:0], 1'b0};
    if (bitcnt_q == 3'h0) begin
      if (lstate_q == LINK_CMD) begin
        shout_d = buffer_byte_count;
      end else if (ctype_q == CMD_REG_WRITE || ctype_q == CMD_BUF_WRITE) begin
        shout_d = shin_q;
      end else begin
        shout_d = read_data;
      end
    end
  end
  always_ff @(negedge serial_clk or posedge port_rst) begin
    if (port_rst) begin
      shout_q <= 8'h00;
      first_q <= 1'b1;
    end else begin
      shout_q <= first_q ? {buffer_byte_count[6:0], 1'b0} : shout_d;
      first_q <= 1'b0;
    end
  end

  // echo of a byte comes out during the following byte slot
  always_comb begin
    if (!reset_out_n) begin
      serial_data_out_line = 1'b0;
      serial_data_out_oe   = 1'b0;
    end else if (!chip_select) begin
      serial_data_out_line = demod_data;
      serial_data_out_oe   = transparent_mode;
    end else begin
      serial_data_out_line = first_q ? buffer_byte_count[7] : shout_q[7];
      serial_data_out_oe   = 1'b1;
    end
  end

  // ---------------- core side, ref_clk domain ----------------
  logic wr_pulse;
  logic off_pulse;
  logic clr_pulse;
  logic tick_s;
  logic tick_last_q;
  logic tick;

  toggle_pulse_sync u_wr_sync (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .toggle_in (wr_tog_q),
    .pulse_out (wr_pulse)
  );
  toggle_pulse_sync u_off_sync (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .toggle_in (off_tog_q),
    .pulse_out (off_pulse)
  );
  toggle_pulse_sync u_clr_sync (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .toggle_in (clr_tog_q),
    .pulse_out (clr_pulse)
  );
  level_sync u_tick_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in (base_digital_tick),
    .sync_out (tick_s)
  );

  // register write strobe and stored mode bits; data must hold until the
  // toggle crosses, so the host has to pause between written bytes
  logic       strobe_q;
  logic       strobe_d;
  logic [4:0] waddr_out_q;
  logic [4:0] waddr_out_d;
  logic [7:0] wdata_out_q;
  logic [7:0] wdata_out_d;
  logic [1:0] opm_q;
  logic [1:0] opm_d;
  logic       irq_q;
  logic       irq_d;
  logic       off_q;
  logic       off_d;

  always_comb begin
    tick        = tick_s & ~tick_last_q;
    strobe_d    = wr_pulse;
    waddr_out_d = wr_pulse ? wr_addr_hold_q : waddr_out_q;
    wdata_out_d = wr_pulse ? wdata_q : wdata_out_q;
    opm_d       = opm_q;
    if (wr_pulse && wr_addr_hold_q == CTRL1_INDEX) begin
      opm_d = {wdata_q[OPM_HIGH_POS], wdata_q[OPM_LOW_POS]};
    end
    irq_d = irq_q;
    if (clr_pulse) begin
      irq_d = 1'b0;
    end
    if (irq_event) begin
      irq_d = 1'b1;
    end
    off_d = off_q;
    if (off_pulse && !analog_supply_enable && !wake_input && (&key_input)) begin
      off_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_last_q <= 1'b0;
      strobe_q    <= 1'b0;
      waddr_out_q <= 5'h00;
      wdata_out_q <= CTRL_RESET_VALUE;
      opm_q       <= 2'h0;
      irq_q       <= 1'b0;
      off_q       <= 1'b0;
    end else begin
      tick_last_q <= tick_s;
      strobe_q    <= strobe_d;
      waddr_out_q <= waddr_out_d;
      wdata_out_q <= wdata_out_d;
      opm_q       <= opm_d;
      irq_q       <= irq_d;
      off_q       <= off_d;
    end
  end

  // polling sequencer
  poll_state_t pstate_q;
  poll_state_t pstate_d;
  logic [SLEEP_CNT_W-1:0] scnt_q;
  logic [SLEEP_CNT_W-1:0] scnt_d;
  logic [15:0]            ucnt_q;
  logic [15:0]            ucnt_d;
  logic                   deliver_q;
  logic                   deliver_d;
  logic                   rx_on;
  logic                   polling;
  logic [SLEEP_CNT_W-1:0] sleep_len;

  always_comb begin
    rx_on   = opm_q[1];
    polling = (opm_q == 2'h2);
    sleep_len = SLEEP_CNT_W'(sleep_field) * SLEEP_CNT_W'(SLEEP_BASE_TICKS)
                * (sleep_extension_bit ? SLEEP_CNT_W'(SLEEP_EXT_FACTOR)
                                       : SLEEP_CNT_W'(1));
    pstate_d  = pstate_q;
    scnt_d    = scnt_q;
    ucnt_d    = ucnt_q;
    deliver_d = deliver_q;
    case (pstate_q)
      POLL_IDLE: begin
        deliver_d = 1'b0;
        if (rx_on) begin
          pstate_d = polling ? POLL_SLEEP : POLL_PLL;
          scnt_d   = SLEEP_CNT_ZERO;
        end
      end
      POLL_SLEEP: begin
        if (tick) begin
          scnt_d = scnt_q + SLEEP_CNT_W'(1);
        end
        if (scnt_q >= sleep_len) begin
          pstate_d = POLL_PLL;
        end
      end
      POLL_PLL: begin
        ucnt_d = STARTUP_CNT_ZERO;
        if (pll_locked) begin
          pstate_d = POLL_SIGPROC;
        end
      end
      POLL_SIGPROC: begin
        if (tick) begin
          ucnt_d = ucnt_q + 16'h0001;
        end
        if (ucnt_q >= 16'(STARTUP_SIG_TICKS)) begin
          pstate_d = POLL_CHECK;
        end
      end
      POLL_CHECK: begin
        if (check_valid) begin
          deliver_d = 1'b1;
        end else if (check_failed && !deliver_q && polling) begin
          pstate_d = POLL_SLEEP;
          scnt_d   = SLEEP_CNT_ZERO;
        end
      end
      default: pstate_d = POLL_IDLE;
    endcase
    if (!rx_on) begin
      pstate_d  = POLL_IDLE;
      deliver_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pstate_q  <= POLL_IDLE;
      scnt_q    <= SLEEP_CNT_ZERO;
      ucnt_q    <= STARTUP_CNT_ZERO;
      deliver_q <= 1'b0;
    end else begin
      pstate_q  <= pstate_d;
      scnt_q    <= scnt_d;
      ucnt_q    <= ucnt_d;
      deliver_q <= deliver_d;
    end
  end

  assign irq_request      = irq_q;
  assign off_mode_request = off_q;
  assign reg_write_strobe = strobe_q;
  assign reg_write_addr   = waddr_out_q;
  assign reg_write_data   = wdata_out_q;
  assign op_mode_low_bit  = opm_q[0];
  assign op_mode_high_bit = opm_q[1];
  assign pll_enable       = (pstate_q == POLL_PLL) | (pstate_q == POLL_SIGPROC)
                            | (pstate_q == POLL_CHECK);
  assign sig_proc_enable  = (pstate_q == POLL_SIGPROC) | (pstate_q == POLL_CHECK);
  assign check_enable     = (pstate_q == POLL_CHECK) & ~deliver_q;
  assign rx_deliver       = deliver_q;
  // idle and sleep are the phases with the radio off
  assign receiver_active  = (pstate_q != POLL_IDLE) & (pstate_q != POLL_SLEEP);
endmodule

// File: src/serial_cmd_pkg.sv
package serial_cmd_pkg;

  // command type field, top three bits of the command byte
  localparam logic [2:0] CMD_BUF_READ  = 3'h0;
  localparam logic [2:0] CMD_BUF_WRITE = 3'h1;
  localparam logic [2:0] CMD_REG_READ  = 3'h2;
  localparam logic [2:0] CMD_REG_WRITE = 3'h3;
  localparam logic [2:0] CMD_POWER_OFF = 3'h4;
  localparam logic [2:0] CMD_IRQ_CLEAR = 3'h5;

  localparam int CMD_TYPE_MSB  = 7;
  localparam int CMD_TYPE_LSB  = 5;
  localparam int CMD_ADDR_MSB  = 4;
  localparam int CMD_ADDR_LSB  = 0;
  localparam int BYTE_BITS     = 8;
  localparam int REG_COUNT     = 32;

  localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
  // control register 1 carries the operating mode bits
  localparam logic [4:0] CTRL1_INDEX      = 5'h01;
  localparam int         OPM_HIGH_POS     = 5;
  localparam int         OPM_LOW_POS      = 4;

  localparam int         SLEEP_BASE_TICKS = 1024;
  localparam int         SLEEP_EXT_FACTOR = 8;
  localparam int         SLEEP_CNT_W      = 19;
  localparam logic [18:0] SLEEP_CNT_ZERO  = 19'h00000;

  // start-up durations in base ticks, plain defaults
  localparam int           STARTUP_SIG_TICKS = 16;
  localparam logic [15:0]  STARTUP_CNT_ZERO  = 16'h0000;

  typedef enum logic [4:0] {
    POLL_IDLE    = 5'h01,
    POLL_SLEEP   = 5'h02,
    POLL_PLL     = 5'h04,
    POLL_SIGPROC = 5'h08,
    POLL_CHECK   = 5'h10
  } poll_state_t;

  typedef enum logic [3:0] {
    LINK_CMD     = 4'h1,
    LINK_DATA    = 4'h2,
    LINK_IGNORE  = 4'h4,
    LINK_DONE    = 4'h8
  } link_state_t;

endpackage

// File: src/level_sync.sv
module level_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// File: src/toggle_pulse_sync.sv
module toggle_pulse_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic toggle_in,
  output logic      pulse_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  logic meta_d;
  logic sync_d;
  logic last_d;

  always_comb begin
    meta_d = toggle_in;
    sync_d = meta_q;
    last_d = sync_q;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  // one ref_clk pulse per toggle of the link side
  assign pulse_out = sync_q ^ last_q;
endmodule

// File: sim/serial_cmd_rx_asserts.sv
module serial_cmd_rx_asserts (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       chip_select,
  input  wire logic       serial_data_out_line,
  input  wire logic       serial_data_out_oe,
  input  wire logic       reset_out_n,
  input  wire logic       transparent_mode,
  input  wire logic       demod_data,
  input  wire logic       analog_supply_enable,
  input  wire logic       wake_input,
  input  wire logic [3:0] key_input,
  input  wire logic [4:0] sleep_field,
  input  wire logic       pll_enable,
  input  wire logic       pll_locked,
  input  wire logic       sig_proc_enable,
  input  wire logic       check_enable,
  input  wire logic       check_failed,
  input  wire logic       rx_deliver,
  input  wire logic       receiver_active,
  input  wire logic       reg_write_strobe,
  input  wire logic       off_mode_request,
  input  wire logic       op_mode_low_bit,
  input  wire logic       op_mode_high_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic off_ok;
  assign off_ok = !analog_supply_enable && !wake_input && (&key_input);
  sequence s_poll_fail;
    check_enable && check_failed && op_mode_high_bit && !op_mode_low_bit && (|sleep_field);
  endsequence
  sequence s_float_case;
    !chip_select && reset_out_n && !transparent_mode;
  endsequence
  a_out_floats: assert property (s_float_case |-> !serial_data_out_oe)
    else $error("data out driven while idle");
  a_transparent_drive: assert property (!chip_select && reset_out_n && transparent_mode
    |-> serial_data_out_oe && serial_data_out_line == demod_data) else $error("no demod on out");
  a_reset_quiet: assert property (!reset_out_n |-> !serial_data_out_oe)
    else $error("out driven in reset");
  a_strobe_pulse: assert property (reg_write_strobe |=> !reg_write_strobe)
    else $error("strobe longer than one cycle");
  a_sig_after_lock: assert property ($rose(sig_proc_enable) |-> $past(pll_locked))
    else $error("sig proc before lock");
  a_fail_sleeps: assert property (s_poll_fail |-> ##[1:3] !receiver_active)
    else $error("no sleep after failed check");
  a_cont_active: assert property ((op_mode_high_bit && op_mode_low_bit)[*8]
    |-> receiver_active) else $error("receiver off in continuous mode");
  a_deliver_valid: assert property ($rose(rx_deliver) |-> $past(check_enable))
    else $error("delivery without check");
  a_off_qualified: assert property ($rose(off_mode_request) |-> off_ok && $past(off_ok))
    else $error("off without qualifiers");
endmodule

bind serial_command_rx_polling serial_cmd_rx_asserts serial_cmd_rx_asserts_i (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .chip_select(chip_select),
  .serial_data_out_line(serial_data_out_line), .serial_data_out_oe(serial_data_out_oe),
  .reset_out_n(reset_out_n), .transparent_mode(transparent_mode), .demod_data(demod_data),
  .analog_supply_enable(analog_supply_enable), .wake_input(wake_input),
  .key_input(key_input), .sleep_field(sleep_field), .pll_enable(pll_enable),
  .pll_locked(pll_locked), .sig_proc_enable(sig_proc_enable), .check_enable(check_enable),
  .check_failed(check_failed), .rx_deliver(rx_deliver), .receiver_active(receiver_active),
  .reg_write_strobe(reg_write_strobe), .off_mode_request(off_mode_request),
  .op_mode_low_bit(op_mode_low_bit), .op_mode_high_bit(op_mode_high_bit));

// File: sim/serial_host_model.sv
module serial_host_model (
  output logic      serial_clk,
  output logic      chip_select,
  output logic      serial_data_in_line,
  input  wire logic serial_data_out_line,
  input  wire logic serial_data_out_oe,
  input  wire logic reset_out_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serial_clk = 1'b0;
    chip_select = 1'b0;
    serial_data_in_line = 1'b1;
  end
  // bytes leave from bit 31 down; clock stands low outside frames
  task automatic frame(input logic [31:0] tx, input int nbytes, output logic [31:0] rx);
    rx = '0;
    wait (reset_out_n === 1'b1);
    chip_select = 1'b1;
    for (int i = 0; i < nbytes * 8; i++) begin
      serial_data_in_line = tx[31 - i];
      #7.5 serial_clk = 1'b1;
      rx[31 - i] = serial_data_out_oe ? serial_data_out_line : 1'bx;
      #7.5 serial_clk = 1'b0;
      // clock rests low between bytes so each byte crosses to the core alone
      if (i % 8 == 7) #200;
    end
    // released line flips so a stale bit never looks valid
    serial_data_in_line = ~serial_data_in_line;
    // hold select so the last byte crosses before port reset
    #200 chip_select = 1'b0;
    #30;
  endtask
endmodule

// File: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, sys_rst, serial_clk, chip_select, serial_data_in_line, reset_out_n;
  logic transparent_mode, analog_supply_enable, wake_input, base_digital_tick;
  logic sleep_extension_bit, demod_data, pll_locked, check_valid, check_failed, irq_event;
  logic serial_data_out_line, serial_data_out_oe, irq_request, off_mode_request;
  logic reg_write_strobe, op_mode_low_bit, op_mode_high_bit, pll_enable, sig_proc_enable;
  logic check_enable, rx_deliver, receiver_active;
  logic [3:0]  key_input;
  logic [4:0]  sleep_field, reg_write_addr;
  logic [7:0]  reg_write_data;
  logic [1:0]  tick_div;
  logic [31:0] rx;
  logic [12:0] wr_q[$];
  int          num_errors, check_count, ticks;
  serial_command_rx_polling serial_command_rx_polling_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .serial_clk(serial_clk), .chip_select(chip_select),
    .serial_data_in_line(serial_data_in_line), .serial_data_out_line(serial_data_out_line),
    .serial_data_out_oe(serial_data_out_oe), .reset_out_n(reset_out_n),
    .transparent_mode(transparent_mode), .analog_supply_enable(analog_supply_enable),
    .wake_input(wake_input), .key_input(key_input), .base_digital_tick(base_digital_tick),
    .sleep_field(sleep_field), .sleep_extension_bit(sleep_extension_bit),
    .buffer_byte_count(8'h37), .read_data(8'hC3), .demod_data(demod_data),
    .pll_locked(pll_locked), .check_valid(check_valid), .check_failed(check_failed),
    .irq_event(irq_event), .irq_request(irq_request), .off_mode_request(off_mode_request),
    .reg_write_strobe(reg_write_strobe), .reg_write_addr(reg_write_addr),
    .reg_write_data(reg_write_data), .op_mode_low_bit(op_mode_low_bit),
    .op_mode_high_bit(op_mode_high_bit), .pll_enable(pll_enable),
    .sig_proc_enable(sig_proc_enable), .check_enable(check_enable), .rx_deliver(rx_deliver),
    .receiver_active(receiver_active));
  serial_host_model serial_host_model_i (
    .serial_clk(serial_clk), .chip_select(chip_select),
    .serial_data_in_line(serial_data_in_line), .serial_data_out_line(serial_data_out_line),
    .serial_data_out_oe(serial_data_out_oe), .reset_out_n(reset_out_n));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // pll model locks one cycle after enable; ticks at a quarter of ref_clk
  always @(negedge ref_clk) begin
    tick_div <= tick_div + 2'h1;
    base_digital_tick <= tick_div[1];
    pll_locked <= pll_enable;
    if (reg_write_strobe === 1'b1) wr_q.push_back({reg_write_addr, reg_write_data});
  end
  always @(posedge base_digital_tick) ticks++;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return pll_enable;
      1: return check_enable;
      2: return receiver_active;
      default: return rx_deliver;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic lvl);
    int n;
    n = 0;
    while (pick(k) !== lvl && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    check("wait state", pick(k), lvl);
  endtask
  task automatic pulse_in(input int k);
    @(negedge ref_clk);
    if (k == 0) check_failed = 1'b1; else if (k == 1) check_valid = 1'b1; else irq_event = 1'b1;
    @(negedge ref_clk);
    {check_failed, check_valid, irq_event} = 3'h0;
  endtask
  task automatic t_codes();
    logic [7:0] ops[5] = '{8'h00, 8'h20, 8'hC0, 8'hE0, 8'h80};
    pulse_in(2);
    repeat (4) @(negedge ref_clk);
    check("irq set", irq_request, 1'b1);
    serial_host_model_i.frame(32'hA000_0000, 1, rx);
    repeat (8) @(negedge ref_clk);
    check("irq clear", irq_request, 1'b0);
    foreach (ops[i]) serial_host_model_i.frame({ops[i], 24'h5A5A5A}, 3, rx);
    serial_host_model_i.frame(32'h4500_0000, 2, rx);
    repeat (8) @(negedge ref_clk);
    check("read data", rx[23:16], 8'hC3);
    check("no writes", wr_q.size(), 0);
    check("off refused", off_mode_request, 1'b0);
  endtask
  task automatic t_write_burst();
    // register 1 gets only mode bits 1,0 (polling); the second byte writes 0x5A to register 2
    serial_host_model_i.frame(32'h6120_5A00, 3, rx);
    repeat (8) @(negedge ref_clk);
    check("count out", rx[31:24], 8'h37);
    check("cmd echo", rx[23:16], 8'h61);
    check("data echo", rx[15:8], 8'h20);
    check("write count", wr_q.size(), 2);
    check("write one", wr_q[0], {5'h01, 8'h20});
    check("write two", wr_q[1], {5'h02, 8'h5A});
    check("mode bits", {op_mode_high_bit, op_mode_low_bit}, 2'b10);
  endtask
  task automatic sleep_run(input int exp);
    int t0;
    wait_for(1, 1'b1);
    pulse_in(0);
    wait_for(2, 1'b0);
    t0 = ticks;
    wait_for(0, 1'b1);
    check("sleep len", (ticks - t0 >= exp - 8) && (ticks - t0 <= exp + 8), 1'b1);
    check("sig waits lock", sig_proc_enable, 1'b0);
  endtask
  task automatic t_polling();
    sleep_run(1024);
    sleep_extension_bit = 1'b1;
    sleep_run(8192);
    wait_for(1, 1'b1);
    pulse_in(1);
    wait_for(3, 1'b1);
    repeat (50) @(negedge ref_clk);
    check("stays active", {receiver_active, rx_deliver}, 2'b11);
  endtask
  task automatic t_modes_and_out();
    serial_host_model_i.frame(32'h6130_0000, 2, rx);
    repeat (60) @(negedge ref_clk);
    check("continuous", receiver_active, 1'b1);
    check("idle float", serial_data_out_oe, 1'b0);
    transparent_mode = 1'b1;
    for (int v = 0; v < 2; v++) begin
      demod_data = v[0];
      @(negedge ref_clk);
      check("transparent", {serial_data_out_oe, serial_data_out_line}, {1'b1, v[0]});
    end
    reset_out_n = 1'b0;
    @(negedge ref_clk);
    check("reset quiet", serial_data_out_oe, 1'b0);
    {reset_out_n, transparent_mode} = 2'b10;
    wake_input = 1'b1;
    analog_supply_enable = 1'b0;
    serial_host_model_i.frame(32'h8000_0000, 1, rx);
    repeat (8) @(negedge ref_clk);
    check("off on wake", off_mode_request, 1'b0);
    wake_input = 1'b0;
    serial_host_model_i.frame(32'h8000_0000, 1, rx);
    repeat (8) @(negedge ref_clk);
    check("off taken", off_mode_request, 1'b1);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    check("off reset", off_mode_request, 1'b0);
  endtask
  initial begin
    {tick_div, ticks, num_errors, check_count} = '0;
    {base_digital_tick, pll_locked, check_valid, check_failed, irq_event} = 5'h00;
    {transparent_mode, demod_data, sleep_extension_bit, wake_input} = 4'h0;
    {sys_rst, reset_out_n, analog_supply_enable} = 3'b111;
    key_input = 4'hF;
    sleep_field = 5'h01;
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_codes();
    t_write_burst();
    t_polling();
    t_modes_and_out();
    end_of_test();
  end
  initial begin
    #4000000;
    num_errors++;
    end_of_test();
  end
endmodule
